// ===== acc_pkg.sv
// Shared constants, register map and state types of the calibration control block
package acc_pkg;

    // APB geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 8;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_RUN_CONTROL = 10'h061;
    localparam logic [9:0] IDX_SETUP = 10'h062;
    localparam logic [9:0] IDX_PROGRESS = 10'h06A;
    localparam logic [9:0] IDX_PIN_SETUP = 10'h06B;
    localparam logic [9:0] IDX_SOFTWARE_KICK = 10'h06C;

    // Reset values
    localparam logic [7:0] RST_RUN_CONTROL = 8'h01;
    localparam logic [7:0] RST_SETUP = 8'h01;
    localparam logic [7:0] RST_PIN_SETUP = 8'h00;
    localparam logic [7:0] RST_SOFTWARE_KICK = 8'h01;

    // Field positions
    localparam int unsigned BIT_CAL_ENABLE = 0;
    localparam int unsigned BIT_FG_CAL = 0;
    localparam int unsigned BIT_BG_CAL = 1;
    localparam int unsigned BIT_FG_OS_CAL = 2;
    localparam int unsigned BIT_BG_OS_CAL = 3;
    localparam int unsigned BIT_OS_FILTER = 4;
    localparam int unsigned BIT_FG_COMPLETE = 0;
    localparam int unsigned BIT_STOPPED = 1;
    localparam int unsigned BIT_TRIG_SRC = 0;
    localparam int unsigned BIT_STAT_SEL_LO = 1;
    localparam int unsigned BIT_SOFT_TRIG = 0;

    // Status pin source selections
    localparam logic [1:0] STATSEL_FOREGROUND_COMPLETE_FLAG = 2'h0;
    localparam logic [1:0] STATSEL_RESERVED = 2'h1;
    localparam logic [1:0] STATSEL_ALARM = 2'h2;
    localparam logic [1:0] STATSEL_LOW = 2'h3;

    // Model durations of the calibration phases
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned FG_CAL_TIME_NS = 1280;
    localparam int unsigned FG_OS_TIME_NS = 640;
    localparam int unsigned FG_CAL_CYCLES = (FG_CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FG_OS_CYCLES = (FG_OS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 12;
    localparam logic [CNT_W-1:0] FG_CAL_LAST = CNT_W'(FG_CAL_CYCLES - 1);
    localparam logic [CNT_W-1:0] FG_OS_LAST = CNT_W'(FG_OS_CYCLES - 1);

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_CLEAR = 3'b001,
        SEQ_FG_RUN = 3'b010,
        SEQ_FG_OS = 3'b011,
        SEQ_BG_RUN = 3'b100,
        SEQ_BG_HOLD = 3'b101,
        SEQ_DONE = 3'b110
    } acc_seq_e;

    typedef struct packed {
        acc_seq_e state;
        logic [CNT_W-1:0] count;
        logic fgDone;
        logic stopped;
    } acc_seq_s;

    typedef struct packed {
        logic [REG_W-1:0] runControl;
        logic [REG_W-1:0] setup;
        logic [REG_W-1:0] pinSetup;
        logic [REG_W-1:0] softwareKick;
        logic [DATA_W-1:0] rdata;
        logic slvErr;
        logic [1:0] trigSync;
        logic [1:0] alarmSync;
        logic statusPin;
        logic dividerReset;
        logic offsetFilter;
    } acc_main_s;

endpackage : acc_pkg

// ===== acc_cal_if.sv
// Control and status bundle between the register bank and the calibration sequencer
`timescale 1ns/1ps
interface acc_cal_if;
    logic calEnable;
    logic fgSelect;
    logic bgSelect;
    logic fgOsSelect;
    logic bgOsSelect;
    logic trigger;
    logic fgDone;
    logic stopped;
    logic fgRun;
    logic fgOsRun;
    logic bgRun;
    logic bgOsRun;
    logic clearValues;

    modport ctl (
        output calEnable, fgSelect, bgSelect, fgOsSelect, bgOsSelect, trigger,
        input fgDone, stopped, fgRun, fgOsRun, bgRun, bgOsRun, clearValues
    );
    modport seq (
        input calEnable, fgSelect, bgSelect, fgOsSelect, bgOsSelect, trigger,
        output fgDone, stopped, fgRun, fgOsRun, bgRun, bgOsRun, clearValues
    );
endinterface : acc_cal_if

// ===== acc_sequencer.sv
// Calibration sequencer: value reset, foreground phases and background run and hold
`timescale 1ns/1ps
module acc_sequencer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Bundle from the register bank
    acc_cal_if.seq cal
);

    acc_pkg::acc_seq_s q;
    acc_pkg::acc_seq_s d;

    always_comb begin
        d = q;
        case (q.state)
            acc_pkg::SEQ_IDLE: begin
                d.count = '0;
                // Idle is left whenever the enable is high, including straight out of reset
                if (cal.calEnable) begin
                    d.state = acc_pkg::SEQ_CLEAR;
                end
            end
            acc_pkg::SEQ_CLEAR: begin
                d.count = '0;
                if (cal.fgSelect) begin
                    d.state = acc_pkg::SEQ_FG_RUN;
                end else if (cal.bgSelect) begin
                    d.state = acc_pkg::SEQ_BG_RUN;
                end else begin
                    d.state = acc_pkg::SEQ_DONE;
                    d.stopped = 1'b1;
                end
            end
            acc_pkg::SEQ_FG_RUN: begin
                // Progress only while the selected trigger is high
                if (cal.trigger) begin
                    d.count = q.count + 1'b1;
                    if (q.count == acc_pkg::FG_CAL_LAST) begin
                        d.count = '0;
                        if (cal.fgOsSelect) begin
                            d.state = acc_pkg::SEQ_FG_OS;
                        end else begin
                            d.fgDone = 1'b1;
                            d.state = cal.bgSelect ? acc_pkg::SEQ_BG_RUN : acc_pkg::SEQ_DONE;
                            d.stopped = !cal.bgSelect;
                        end
                    end
                end
            end
            acc_pkg::SEQ_FG_OS: begin
                if (cal.trigger) begin
                    d.count = q.count + 1'b1;
                    if (q.count == acc_pkg::FG_OS_LAST) begin
                        d.count = '0;
                        d.fgDone = 1'b1;
                        d.state = cal.bgSelect ? acc_pkg::SEQ_BG_RUN : acc_pkg::SEQ_DONE;
                        d.stopped = !cal.bgSelect;
                    end
                end
            end
            acc_pkg::SEQ_BG_RUN: begin
                // A low trigger requests the background engine to park
                if (!cal.trigger) begin
                    d.state = acc_pkg::SEQ_BG_HOLD;
                    d.stopped = 1'b1;
                end
            end
            acc_pkg::SEQ_BG_HOLD: begin
                if (cal.trigger) begin
                    d.state = acc_pkg::SEQ_BG_RUN;
                    d.stopped = 1'b0;
                end
            end
            acc_pkg::SEQ_DONE: begin
                d.state = acc_pkg::SEQ_DONE;
            end
            default: begin
                d.state = acc_pkg::SEQ_IDLE;
            end
        endcase
        // Enable low holds everything in reset, whatever the state
        if (!cal.calEnable) begin
            d.state = acc_pkg::SEQ_IDLE;
            d.count = '0;
            d.fgDone = 1'b0;
            d.stopped = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= '{state: acc_pkg::SEQ_IDLE, count: '0, fgDone: 1'b0, stopped: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign cal.fgDone = q.fgDone;
    assign cal.stopped = q.stopped;
    assign cal.clearValues = (q.state == acc_pkg::SEQ_CLEAR);
    // Gated by the enable so a hold stops the engines in the same cycle
    assign cal.fgRun = (q.state == acc_pkg::SEQ_FG_RUN) && cal.trigger && cal.calEnable;
    assign cal.fgOsRun = (q.state == acc_pkg::SEQ_FG_OS) && cal.trigger && cal.calEnable;
    assign cal.bgRun = (q.state == acc_pkg::SEQ_BG_RUN) && cal.calEnable;
    // Offset tracking rides on the background engine only
    assign cal.bgOsRun = cal.bgRun && cal.bgOsSelect;

endmodule : acc_sequencer

// ===== acc_calibration_control.sv
// Calibration control register bank with APB slave, trigger selection and status pin routing
//
// Operation
// - Calibration runs while the enable bit is 1 (its reset value) and is held in reset while 0.
// - Clearing the enable bit also resets the dividers clocking the digital and serial blocks.
// - Setup bit 4 turns offset filtering on when 1 and resets to 0.
// - Setup bit 3 enables background offset calibration, effective only with background on.
// - Setup bit 2 enables foreground offset calibration, which needs foreground selected.
// - Setup bit 1 enables background calibration; it is sampled only when background would start, so clearing it later does not stop a run.
// - Setup bit 0 clears calibration values and then runs foreground calibration or skips it.
// - Progress bit 1 reads 1 once background calibration has parked and 0 when it resumes.
// - With background off, the stopped bit sets once foreground is complete or skipped.
// - Progress bit 0 goes high when foreground calibration completes; progress is read only.
// - The pin select field drives the status pin: done, reserved, alarm, or held low.
// - Trigger source bit 0 picks the software bit at 0 or the hardware pin at 1.
// - The software trigger bit resets to 1 and stands in for the hardware pin.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module acc_calibration_control (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic [acc_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [acc_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [acc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device pins
    input wire logic hardwareTriggerInput,
    input wire logic alarmIn,
    output logic statusOutputPin,
    // Controls toward the converter core
    output logic dividerReset,
    output logic calHeldInReset,
    output logic calValuesClear,
    output logic fgCalRun,
    output logic fgOffsetCalRun,
    output logic bgCalRun,
    output logic bgOffsetCalRun,
    output logic offsetFilterEnable
);

    localparam int unsigned DW = acc_pkg::DATA_W;
    localparam int unsigned RW = acc_pkg::REG_W;
    localparam int unsigned IW = acc_pkg::ADDR_W - 2;
    localparam int unsigned SW = 2;

    // Registered state of the bank
    acc_pkg::acc_main_s q;
    acc_pkg::acc_main_s d;

    // Bundle toward the calibration sequencer
    acc_cal_if calBus ();

    // Bus decode
    logic [IW-1:0] regIdx;
    logic setupPhase;
    logic accessPhase;
    logic wrCommit;
    logic idxHit;
    logic [RW-1:0] rdByte;
    logic [RW-1:0] progressByte;
    logic [RW-1:0] wrByte;

    // Register selects
    logic selRunControl;
    logic selSetup;
    logic selProgress;
    logic selPinSetup;
    logic selSoftwareKick;

    // Write strobes
    logic wrRunControl;
    logic wrSetup;
    logic wrPinSetup;
    logic wrSoftwareKick;

    // Derived controls
    logic calEnable;
    logic trigSource;
    logic softTrigger;
    logic hardTriggerSync;
    logic alarmSync;
    logic selectedTrigger;
    logic [SW-1:0] statusSel;
    logic statusNext;

    // APB phases
    assign regIdx = paddr[acc_pkg::ADDR_W-1:2];
    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;

    // Every access completes in its first access cycle, so no wait states
    assign pready = accessPhase;

    // Only byte lane 0 carries register bits
    assign wrCommit = accessPhase && pready && pwrite && pstrb[0];
    assign wrByte = pwdata[RW-1:0];

    // Address selects
    assign selRunControl = (regIdx == acc_pkg::IDX_RUN_CONTROL);
    assign selSetup = (regIdx == acc_pkg::IDX_SETUP);
    assign selProgress = (regIdx == acc_pkg::IDX_PROGRESS);
    assign selPinSetup = (regIdx == acc_pkg::IDX_PIN_SETUP);
    assign selSoftwareKick = (regIdx == acc_pkg::IDX_SOFTWARE_KICK);

    // Unmapped offsets answer with an error and change nothing
    assign idxHit = selRunControl
        || selSetup
        || selProgress
        || selPinSetup
        || selSoftwareKick;

    // Progress is read only; a write to it completes and is dropped
    assign wrRunControl = wrCommit && selRunControl;
    assign wrSetup = wrCommit && selSetup;
    assign wrPinSetup = wrCommit && selPinSetup;
    assign wrSoftwareKick = wrCommit && selSoftwareKick;

    // Field extraction
    assign calEnable = q.runControl[acc_pkg::BIT_CAL_ENABLE];
    assign trigSource = q.pinSetup[acc_pkg::BIT_TRIG_SRC];
    assign softTrigger = q.softwareKick[acc_pkg::BIT_SOFT_TRIG];
    assign statusSel = q.pinSetup[acc_pkg::BIT_STAT_SEL_LO +: SW];

    // Only the second synchroniser stage feeds logic
    assign hardTriggerSync = q.trigSync[1];
    assign alarmSync = q.alarmSync[1];

    // The unselected trigger source is ignored entirely
    assign selectedTrigger = trigSource ? hardTriggerSync : softTrigger;

    // Controls handed to the sequencer
    assign calBus.calEnable = calEnable;
    assign calBus.fgSelect = q.setup[acc_pkg::BIT_FG_CAL];
    assign calBus.bgSelect = q.setup[acc_pkg::BIT_BG_CAL];
    assign calBus.fgOsSelect = q.setup[acc_pkg::BIT_FG_OS_CAL];
    assign calBus.bgOsSelect = q.setup[acc_pkg::BIT_BG_OS_CAL];
    assign calBus.trigger = selectedTrigger;

    acc_sequencer acc_sequencer_inst (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cal(calBus)
    );

    // Progress byte: reserved bits read as zero
    always_comb begin
        progressByte = '0;
        progressByte[acc_pkg::BIT_FG_COMPLETE] = calBus.fgDone;
        progressByte[acc_pkg::BIT_STOPPED] = calBus.stopped;
    end

    // Read multiplexer
    always_comb begin
        rdByte = '0;
        case (regIdx)
            acc_pkg::IDX_RUN_CONTROL: begin
                rdByte = q.runControl;
            end
            acc_pkg::IDX_SETUP: begin
                rdByte = q.setup;
            end
            acc_pkg::IDX_PROGRESS: begin
                rdByte = progressByte;
            end
            acc_pkg::IDX_PIN_SETUP: begin
                rdByte = q.pinSetup;
            end
            acc_pkg::IDX_SOFTWARE_KICK: begin
                rdByte = q.softwareKick;
            end
            default: begin
                rdByte = '0;
            end
        endcase
    end

    // Status pin source; the reserved code drives low so the pin never floats
    always_comb begin
        statusNext = 1'b0;
        case (statusSel)
            acc_pkg::STATSEL_FOREGROUND_COMPLETE_FLAG: begin
                statusNext = calBus.fgDone;
            end
            acc_pkg::STATSEL_RESERVED: begin
                statusNext = 1'b0;
            end
            acc_pkg::STATSEL_ALARM: begin
                statusNext = alarmSync;
            end
            acc_pkg::STATSEL_LOW: begin
                statusNext = 1'b0;
            end
            default: begin
                statusNext = 1'b0;
            end
        endcase
    end

    // Next state of the whole bank
    always_comb begin
        d = q;

        // Two-stage synchronisers for the asynchronous pins
        d.trigSync = {q.trigSync[0], hardwareTriggerInput};
        d.alarmSync = {q.alarmSync[0], alarmIn};

        // Register writes land at the completing access edge
        if (wrRunControl) begin
            d.runControl = wrByte;
        end
        if (wrSetup) begin
            d.setup = wrByte;
        end
        if (wrPinSetup) begin
            d.pinSetup = wrByte;
        end
        if (wrSoftwareKick) begin
            d.softwareKick = wrByte;
        end

        // Read data and error are captured in the setup cycle
        // so they stand unchanged through the access phase
        if (setupPhase) begin
            d.rdata = DW'(rdByte);
            d.slvErr = !idxHit;
        end

        // Status pin comes from a flip-flop to keep it glitch free
        d.statusPin = statusNext;

        // Dividers stay in reset for as long as calibration is held
        d.dividerReset = !calEnable;

        // Filtering follows its setup bit
        d.offsetFilter = q.setup[acc_pkg::BIT_OS_FILTER];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q.runControl <= acc_pkg::RST_RUN_CONTROL;
            q.setup <= acc_pkg::RST_SETUP;
            q.pinSetup <= acc_pkg::RST_PIN_SETUP;
            q.softwareKick <= acc_pkg::RST_SOFTWARE_KICK;
            q.rdata <= '0;
            q.slvErr <= 1'b0;
            q.trigSync <= '0;
            q.alarmSync <= '0;
            q.statusPin <= 1'b0;
            q.dividerReset <= 1'b0;
            q.offsetFilter <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // Bus outputs
    assign prdata = q.rdata;
    assign pslverr = q.slvErr;

    // Pin and core outputs
    assign statusOutputPin = q.statusPin;
    assign dividerReset = q.dividerReset;
    assign calHeldInReset = !calEnable;
    assign calValuesClear = calBus.clearValues;
    assign fgCalRun = calBus.fgRun;
    assign fgOffsetCalRun = calBus.fgOsRun;
    assign bgCalRun = calBus.bgRun;
    assign bgOffsetCalRun = calBus.bgOsRun;
    assign offsetFilterEnable = q.offsetFilter;

endmodule : acc_calibration_control

// ===== acc_host_pins.sv
// Host-side pin driver: hardware trigger and alarm levels
`timescale 1ns/1ps
module acc_host_pins (
    // Clock and commanded levels
    input wire logic sys_clk,
    input wire logic trigLevel,
    input wire logic alarmLevel,
    // Pins into the device
    output logic hardwareTriggerInput,
    output logic alarmIn
);
    // Levels change only after a clock edge, as a real host would
    always_ff @(posedge sys_clk) begin
        hardwareTriggerInput <= trigLevel;
        alarmIn <= alarmLevel;
    end
endmodule : acc_host_pins

// ===== acc_calibration_control_props.sv
// Port-level assertions for the calibration control block
`timescale 1ns/1ps
module acc_calibration_control_props (
    // Clock, reset and bus
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [acc_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [acc_pkg::DATA_W-1:0] pwdata,
    input wire logic pready,
    // Device outputs
    input wire logic statusOutputPin,
    input wire logic dividerReset,
    input wire logic calHeldInReset,
    input wire logic calValuesClear,
    input wire logic fgCalRun,
    input wire logic fgOffsetCalRun,
    input wire logic bgCalRun,
    input wire logic bgOffsetCalRun,
    input wire logic offsetFilterEnable
);
    logic [7:0] setup_q;
    logic [7:0] pin_q;
    logic wrDone;
    assign wrDone = psel && penable && pready && pwrite;
    // Shadow copies so outputs can be tied to the written settings
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            setup_q <= acc_pkg::RST_SETUP;
            pin_q <= acc_pkg::RST_PIN_SETUP;
        end else if (wrDone && paddr[11:2] == acc_pkg::IDX_SETUP) begin
            setup_q <= pwdata[7:0];
        end else if (wrDone && paddr[11:2] == acc_pkg::IDX_PIN_SETUP) begin
            pin_q <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence cfgSteady;
        $stable(setup_q)[*3];
    endsequence
    sequence pinLowSel;
        (pin_q[2:1] == 2'h3)[*3];
    endsequence
    a_held_stops_run: assert property (calHeldInReset |-> !(fgCalRun || bgCalRun))
        else $error("calibration runs while held");
    a_divider_on_hold: assert property ($rose(calHeldInReset) |-> ##[0:2] dividerReset)
        else $error("dividers not reset on disable");
    a_filter_follows: assert property (cfgSteady |-> offsetFilterEnable == setup_q[4])
        else $error("offset filter mismatch");
    a_bg_offset_gated: assert property (bgOffsetCalRun |-> setup_q[3] && setup_q[1])
        else $error("background offset without background");
    a_fg_offset_gated: assert property (fgOffsetCalRun |-> setup_q[2] && setup_q[0])
        else $error("foreground offset without foreground");
    a_bg_needs_select: assert property (bgCalRun |-> setup_q[1])
        else $error("background runs unselected");
    a_fg_needs_select: assert property (fgCalRun |-> setup_q[0])
        else $error("foreground runs unselected");
    a_pin_held_low: assert property (pinLowSel |-> !statusOutputPin)
        else $error("status pin not low");
    a_restart_clears: assert property ($fell(calHeldInReset) |-> ##[0:8] calValuesClear)
        else $error("no value clear on restart");
endmodule : acc_calibration_control_props
bind acc_calibration_control acc_calibration_control_props acc_calibration_control_props_inst (.*);

// ===== adc_calibration_control_test.sv
// Register-level testbench for the calibration control block
`timescale 1ns/1ps
module adc_calibration_control_test;
    logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, trigLevel = 0;
    logic alarmLevel = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic err;
    logic pready, pslverr, hwTrig, alarmIn, statPin, divRst, held, clr, fgR, fgOsR, bgR, bgOsR, filt;
    int num_errors = 0, cmp_count = 0;
    acc_calibration_control acc_calibration_control_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hardwareTriggerInput(hwTrig), .alarmIn(alarmIn), .statusOutputPin(statPin),
        .dividerReset(divRst), .calHeldInReset(held), .calValuesClear(clr), .fgCalRun(fgR),
        .fgOffsetCalRun(fgOsR), .bgCalRun(bgR), .bgOffsetCalRun(bgOsR),
        .offsetFilterEnable(filt));
    acc_host_pins acc_host_pins_inst (.sys_clk(sys_clk), .trigLevel(trigLevel),
        .alarmLevel(alarmLevel), .hardwareTriggerInput(hwTrig), .alarmIn(alarmIn));
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic report_and_stop;
        if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Waits on pready itself; the watchdog is the only limit
    task automatic xfer(input logic [9:0] idx, input logic wr, input logic [7:0] wd);
        @(posedge sys_clk);
        paddr <= {idx, 2'b00};
        pwrite <= wr;
        pwdata <= {24'h0, wd};
        psel <= 1;
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : xfer
    task automatic rdChk(input string what, input logic [9:0] idx, input logic [7:0] exp);
        xfer(idx, 0, 8'h00);
        check(what, exp, rd[7:0]);
    endtask : rdChk
    task automatic pollProg(input logic [1:0] mask, input logic [1:0] exp);
        xfer(acc_pkg::IDX_PROGRESS, 0, 8'h00);
        for (int i = 0; i < 300 && (rd[1:0] & mask) !== exp; i++) begin
            xfer(acc_pkg::IDX_PROGRESS, 0, 8'h00);
        end
        check("progress", {6'h0, exp}, {6'h0, rd[1:0] & mask});
    endtask : pollProg
    task automatic restart(input logic [7:0] setup, input logic [7:0] pins);
        xfer(acc_pkg::IDX_RUN_CONTROL, 1, 8'h00);
        xfer(acc_pkg::IDX_SETUP, 1, setup);
        xfer(acc_pkg::IDX_PIN_SETUP, 1, pins);
        xfer(acc_pkg::IDX_RUN_CONTROL, 1, 8'h01);
        rd = '0;
    endtask : restart
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1;
        rdChk("run", acc_pkg::IDX_RUN_CONTROL, 8'h01);
        rdChk("setup", acc_pkg::IDX_SETUP, 8'h01);
        rdChk("pins", acc_pkg::IDX_PIN_SETUP, 8'h00);
        rdChk("kick", acc_pkg::IDX_SOFTWARE_KICK, 8'h01);
        pollProg(2'h3, 2'h3);
        check("pin", {7'h0, 1'b1}, {7'h0, statPin});
        xfer(acc_pkg::IDX_RUN_CONTROL, 1, 8'h00);
        repeat (2) @(negedge sys_clk);
        check("held", 8'h01, {7'h0, held});
        check("divRst", 8'h01, {7'h0, divRst});
        restart(8'h1A, 8'h04);
        check("filter", 8'h01, {7'h0, filt});
        for (int i = 0; i < 300 && bgR !== 1'b1; i++) @(posedge sys_clk);
        check("bgRun", 8'h01, {7'h0, bgR});
        alarmLevel <= 1;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        check("alarmPin", 8'h01, {7'h0, statPin});
        restart(8'h00, 8'h06);
        pollProg(2'h2, 2'h2);
        check("lowPin", 8'h00, {7'h0, statPin});
        restart(8'h05, 8'h01);
        repeat (150) @(posedge sys_clk);
        pollProg(2'h1, 2'h0);
        trigLevel <= 1;
        pollProg(2'h1, 2'h1);
        xfer(10'h070, 1, 8'h00);
        check("slverr", 8'h01, {7'h0, err});
        rdChk("run", acc_pkg::IDX_RUN_CONTROL, 8'h01);
        report_and_stop();
    end
    initial begin
        #(20 * 60000);
        num_errors++;
        report_and_stop();
    end
endmodule : adc_calibration_control_test
